// ==== i2cm_pkg.sv ====
// constants, field layout and state encoding of the i2c master transfer control
package i2cm_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] ADR_DIV = 5'h00;
	localparam logic [4:0] ADR_WORDS = 5'h04;
	localparam logic [4:0] ADR_TADDR = 5'h08;
	localparam logic [4:0] ADR_DATA = 5'h0C;
	localparam logic [4:0] ADR_CMD = 5'h10;
	localparam logic [4:0] ADR_STATUS = 5'h14;
	localparam logic [4:0] ADR_TALLY = 5'h18;
	localparam logic [4:0] ADR_CTRL = 5'h1C;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int DIV_W = 8;
	localparam int DIV_FAST_BIT = 31;
	localparam int WORDS_W = 11;
	localparam int TADDR_DIR_BIT = 0;
	localparam int TADDR_LSB = 1;
	localparam int TADDR_MSB = 10;
	localparam int TADDR_A10_BIT = 15;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int CMD_CANCEL_BIT = 2;
	localparam int CTRL_POLICY_BIT = 0;
	localparam int ST_IDLE_BIT = 1;
	localparam int ST_WAITING_BIT = 2;
	localparam int ST_STALLED_BIT = 3;
	localparam int ST_NACKADDR_BIT = 5;
	localparam int ST_NACKDATA_BIT = 6;
	localparam int ST_RXNEMPTY_BIT = 8;
	localparam int ST_TXEMPTY_BIT = 12;
	// ---------------------------------------------------------------
	// reset values and fixed figures
	// ---------------------------------------------------------------
	localparam logic [7:0] DIV_RST = 8'h18;
	localparam logic [10:0] WORDS_RST = 11'h001;
	localparam logic [10:0] WORDS_CONT = 11'h7FF;
	localparam logic [10:0] TALLY_MAX = 11'h7FE;
	localparam logic [4:0] MULT_STD = 5'h14;
	localparam logic [4:0] MULT_FAST = 5'h19;
	localparam logic [4:0] HDR10 = 5'h1E;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_PREP = 4'h9;
	// ---------------------------------------------------------------
	// controller states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_ADDR = 3'h3,
		ST_TXD = 3'h2,
		ST_RXD = 3'h6,
		ST_STOP = 3'h7,
		ST_WAIT = 3'h5
	} i2cm_state_e;
endpackage

// ==== i2cm_tick.sv ====
// internal bit-timing clock divider: one tick every (1 + divider) system clocks
`timescale 1ns/10ps
module i2cm_tick (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic [i2cm_pkg::DIV_W-1:0] i_div,
	output logic o_tick
);
	import i2cm_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic tick;
	} i2cm_tick_s;

	i2cm_tick_s s_ff;
	i2cm_tick_s nxt_s;

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.tick = (s_ff.cnt == '0);
		nxt_s.cnt = (s_ff.cnt == '0) ? i_div : s_ff.cnt - 8'h01;
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign o_tick = s_ff.tick;

	tick_period_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(o_tick && (i_div == 8'h04)) ##1 (i_div == 8'h04) [*4] |=> o_tick)
		else $error("tick period is not divider plus one");
endmodule // i2cm_tick

// ==== i2cm_ctrl.sv ====
// i2c master transfer control: divider, word count, address, data fifos, command
`timescale 1ns/10ps
module i2cm_ctrl #(
	parameter int FIFO_AW = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic [i2cm_pkg::ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_scl,
	output logic o_scl,
	output logic o_scl_oe_n,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n
);
	import i2cm_pkg::*;

	localparam int FIFO_DEPTH = 1 << FIFO_AW;
	localparam logic [FIFO_AW:0] FIFO_FULL = (FIFO_AW+1)'(FIFO_DEPTH);

	typedef struct packed {
		logic fast;
		logic [DIV_W-1:0] div;
		logic [WORDS_W-1:0] words;
		logic a10;
		logic [9:0] taddr;
		logic dir;
		logic policy;
		logic [FIFO_DEPTH-1:0][7:0] txm;
		logic [FIFO_AW:0] txc;
		logic [FIFO_AW-1:0] txr;
		logic [FIFO_AW-1:0] txw;
		logic [FIFO_DEPTH-1:0][7:0] rxm;
		logic [FIFO_AW:0] rxc;
		logic [FIFO_AW-1:0] rxr;
		logic [FIFO_AW-1:0] rxw;
		i2cm_state_e st;
		logic [4:0] ph;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic [1:0] astep;
		logic smp;
		logic stop_req;
		logic stalled;
		logic nack_a;
		logic nack_d;
		logic [WORDS_W-1:0] sent;
		logic [WORDS_W-1:0] rcvd;
		logic scl_oe_n;
		logic sda_oe_n;
		logic [31:0] rdata;
	} i2cm_ctrl_s;

	i2cm_ctrl_s s_ff;
	i2cm_ctrl_s nxt_s;
	logic tick;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic rx_pop;
	logic [4:0] mult;
	logic [4:0] half;
	logic [4:0] samp;
	logic last_ph;
	logic stretch;
	logic last_rx;
	logic [31:0] status;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [4:0] bit_mult(input logic fast);
		return fast ? MULT_FAST : MULT_STD;
	endfunction

	function automatic logic [10:0] sat_inc(input logic [10:0] v);
		return (v >= TALLY_MAX) ? TALLY_MAX : v + 11'h001;
	endfunction

	function automatic i2cm_state_e end_state(input logic stop_req);
		return stop_req ? ST_STOP : ST_WAIT;
	endfunction

	i2cm_tick u_tick (
		.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n),
		.i_div(s_ff.div),
		.o_tick(tick)
	);

	// ---------------------------------------------------------------
	// transfer engine, register port and fifos
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_s = s_ff;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		mult = bit_mult(s_ff.fast);
		half = {1'b0, mult[4:1]};
		samp = half + {2'b00, mult[4:2]};
		last_ph = (s_ff.ph == mult - 5'h01);
		// a slave holding scl low freezes the high half of the bit
		stretch = s_ff.scl_oe_n && !i_scl && (s_ff.ph >= half);
		// the received count stops at its cap, so an all-ones count ends at the cap
		last_rx = (({1'b0, s_ff.rcvd} + 12'h001) >= {1'b0, s_ff.words})
			|| ((s_ff.rcvd + 11'h001) >= TALLY_MAX);
		status = '0;
		status[ST_IDLE_BIT] = (s_ff.st == ST_IDLE);
		status[ST_WAITING_BIT] = (s_ff.st == ST_WAIT);
		status[ST_STALLED_BIT] = s_ff.stalled;
		status[ST_NACKADDR_BIT] = s_ff.nack_a;
		status[ST_NACKDATA_BIT] = s_ff.nack_d;
		status[ST_RXNEMPTY_BIT] = (s_ff.rxc != '0);
		status[ST_TXEMPTY_BIT] = (s_ff.txc == '0);

		if (tick && s_ff.bitn == BIT_PREP && s_ff.st == ST_TXD)
		begin
			nxt_s.stalled = 1'b0;
			if (s_ff.sent >= s_ff.words)
				nxt_s.st = end_state(s_ff.stop_req);
			else if (s_ff.txc == '0)
			begin
				if (s_ff.policy && s_ff.sent != '0)
					nxt_s.st = end_state(s_ff.stop_req);
				else
					nxt_s.stalled = 1'b1;
			end
			else
			begin
				tx_pop = 1'b1;
				nxt_s.sh = s_ff.txm[s_ff.txr];
				nxt_s.bitn = 4'h0;
			end
		end
		else if (tick && s_ff.bitn == BIT_PREP && s_ff.st == ST_RXD)
		begin
			nxt_s.stalled = 1'b0;
			if (s_ff.rcvd >= s_ff.words || s_ff.rcvd == TALLY_MAX)
				nxt_s.st = end_state(s_ff.stop_req);
			else if (s_ff.rxc == FIFO_FULL)
				nxt_s.stalled = 1'b1;
			else
				nxt_s.bitn = 4'h0;
		end
		else if (tick && s_ff.bitn == BIT_PREP && s_ff.st == ST_ADDR)
			nxt_s.st = ST_START;
		else if (tick && !stretch && s_ff.st != ST_IDLE && s_ff.st != ST_WAIT)
		begin
			if (s_ff.ph == samp)
				nxt_s.smp = i_sda;
			nxt_s.ph = last_ph ? 5'h00 : s_ff.ph + 5'h01;
			if (last_ph)
			begin
				case (s_ff.st)
					ST_START:
					begin
						nxt_s.st = ST_ADDR;
						nxt_s.bitn = 4'h0;
						if (s_ff.astep == 2'h2)
							nxt_s.sh = {HDR10, s_ff.taddr[9:8], 1'b1};
						else if (s_ff.a10)
							nxt_s.sh = {HDR10, s_ff.taddr[9:8], 1'b0};
						else
							nxt_s.sh = {s_ff.taddr[6:0], s_ff.dir};
					end
					ST_STOP:
						nxt_s.st = ST_IDLE;
					ST_ADDR, ST_TXD, ST_RXD:
					begin
						if (s_ff.bitn != BIT_ACK)
						begin
							nxt_s.sh = {s_ff.sh[6:0], s_ff.smp};
							nxt_s.bitn = s_ff.bitn + 4'h1;
						end
						else if (s_ff.st == ST_ADDR)
						begin
							if (s_ff.smp)
							begin
								nxt_s.nack_a = 1'b1;
								nxt_s.st = end_state(s_ff.stop_req);
							end
							else if (s_ff.a10 && s_ff.astep == 2'h0)
							begin
								nxt_s.astep = 2'h1;
								nxt_s.sh = s_ff.taddr[7:0];
								nxt_s.bitn = 4'h0;
							end
							else if (s_ff.a10 && s_ff.astep == 2'h1 && s_ff.dir)
							begin
								// one low tick lets the slave drop its ack before the restart
								nxt_s.astep = 2'h2;
								nxt_s.bitn = BIT_PREP;
							end
							else
							begin
								nxt_s.st = s_ff.dir ? ST_RXD : ST_TXD;
								nxt_s.bitn = BIT_PREP;
							end
						end
						else if (s_ff.st == ST_TXD)
						begin
							nxt_s.sent = sat_inc(s_ff.sent);
							nxt_s.bitn = BIT_PREP;
							if (s_ff.smp)
							begin
								nxt_s.nack_d = 1'b1;
								nxt_s.st = end_state(s_ff.stop_req);
							end
						end
						else
						begin
							rx_push = 1'b1;
							nxt_s.rcvd = sat_inc(s_ff.rcvd);
							nxt_s.bitn = BIT_PREP;
						end
					end
					default:
						nxt_s.st = ST_IDLE;
				endcase
			end
		end

		// register writes
		if (i_wr)
		begin
			case (i_addr)
				ADR_DIV:
				begin
					nxt_s.fast = i_wdata[DIV_FAST_BIT];
					nxt_s.div = i_wdata[DIV_W-1:0];
				end
				ADR_WORDS:
					nxt_s.words = i_wdata[WORDS_W-1:0];
				ADR_TADDR:
				begin
					nxt_s.dir = i_wdata[TADDR_DIR_BIT];
					nxt_s.taddr = i_wdata[TADDR_MSB:TADDR_LSB];
					nxt_s.a10 = i_wdata[TADDR_A10_BIT];
				end
				ADR_DATA:
					tx_push = (s_ff.txc != FIFO_FULL);
				ADR_CTRL:
					nxt_s.policy = i_wdata[CTRL_POLICY_BIT];
				ADR_CMD:
				begin
					if (s_ff.st == ST_IDLE || s_ff.st == ST_WAIT)
					begin
						if (i_wdata[CMD_START_BIT])
						begin
							nxt_s.st = ST_START;
							nxt_s.stop_req = i_wdata[CMD_STOP_BIT];
							nxt_s.ph = 5'h00;
							nxt_s.astep = 2'h0;
							nxt_s.sent = '0;
							nxt_s.rcvd = '0;
							nxt_s.nack_a = 1'b0;
							nxt_s.nack_d = 1'b0;
							nxt_s.stalled = 1'b0;
						end
						else if (i_wdata[CMD_STOP_BIT] && s_ff.st == ST_WAIT)
						begin
							nxt_s.st = ST_STOP;
							nxt_s.ph = 5'h00;
						end
					end
					else if (i_wdata[CMD_CANCEL_BIT])
					begin
						nxt_s.st = ST_STOP;
						nxt_s.ph = 5'h00;
						nxt_s.stalled = 1'b0;
					end
				end
				default:
					nxt_s.fast = nxt_s.fast;
			endcase
		end

		// register reads, data valid only in the cycle after the strobe
		nxt_s.rdata = '0;
		if (i_rd)
		begin
			case (i_addr)
				ADR_DIV:
					nxt_s.rdata = {s_ff.fast, 23'h000000, s_ff.div};
				ADR_WORDS:
					nxt_s.rdata = {21'h000000, s_ff.words};
				ADR_TADDR:
					nxt_s.rdata = {16'h0000, s_ff.a10, 4'h0, s_ff.taddr, s_ff.dir};
				ADR_DATA:
				begin
					rx_pop = (s_ff.rxc != '0);
					if (s_ff.rxc != '0)
						nxt_s.rdata = {24'h000000, s_ff.rxm[s_ff.rxr]};
				end
				ADR_STATUS:
					nxt_s.rdata = status;
				ADR_TALLY:
					nxt_s.rdata = {21'h000000, s_ff.sent};
				ADR_CTRL:
					nxt_s.rdata = {31'h00000000, s_ff.policy};
				default:
					nxt_s.rdata = '0;
			endcase
		end

		// fifo pointers; push and pop may meet in one cycle
		if (tx_push)
		begin
			nxt_s.txm[s_ff.txw] = i_wdata[7:0];
			nxt_s.txw = s_ff.txw + FIFO_AW'(1);
		end
		if (tx_pop)
			nxt_s.txr = s_ff.txr + FIFO_AW'(1);
		nxt_s.txc = s_ff.txc + (FIFO_AW+1)'(tx_push) - (FIFO_AW+1)'(tx_pop);
		if (rx_push)
		begin
			nxt_s.rxm[s_ff.rxw] = s_ff.sh;
			nxt_s.rxw = s_ff.rxw + FIFO_AW'(1);
		end
		if (rx_pop)
			nxt_s.rxr = s_ff.rxr + FIFO_AW'(1);
		nxt_s.rxc = s_ff.rxc + (FIFO_AW+1)'(rx_push) - (FIFO_AW+1)'(rx_pop);

		// pin drive from the next state, low enable pulls the wire low
		case (nxt_s.st)
			ST_START:
			begin
				nxt_s.scl_oe_n = (nxt_s.ph < samp);
				nxt_s.sda_oe_n = (nxt_s.ph < half);
			end
			ST_STOP:
			begin
				nxt_s.scl_oe_n = (nxt_s.ph >= half);
				nxt_s.sda_oe_n = (nxt_s.ph >= samp);
			end
			ST_ADDR, ST_TXD, ST_RXD:
			begin
				nxt_s.scl_oe_n = (nxt_s.ph >= half);
				if (nxt_s.bitn < BIT_ACK)
					nxt_s.sda_oe_n = (nxt_s.st == ST_RXD) ? 1'b1 : nxt_s.sh[7];
				else if (nxt_s.bitn == BIT_ACK)
					nxt_s.sda_oe_n = (nxt_s.st == ST_RXD) ? last_rx : 1'b1;
			end
			ST_WAIT:
				nxt_s.scl_oe_n = 1'b0;
			default:
			begin
				nxt_s.scl_oe_n = 1'b1;
				nxt_s.sda_oe_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s_ff <= '0;
			s_ff.div <= DIV_RST;
			s_ff.words <= WORDS_RST;
			s_ff.st <= ST_IDLE;
			s_ff.scl_oe_n <= 1'b1;
			s_ff.sda_oe_n <= 1'b1;
		end
		else
			s_ff <= nxt_s;
	end

	assign o_rdata = s_ff.rdata;
	assign o_scl = 1'b0;
	assign o_sda = 1'b0;
	assign o_scl_oe_n = s_ff.scl_oe_n;
	assign o_sda_oe_n = s_ff.sda_oe_n;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_arst_n);

	std_phase_a: assert property (!s_ff.fast |-> s_ff.ph < 5'h14)
		else $error("standard phase beyond twenty");
	start_cmd_a: assert property (i_wr && i_addr == ADR_CMD && i_wdata[CMD_START_BIT]
		&& s_ff.st == ST_IDLE |=> s_ff.st == ST_START && s_ff.stop_req == $past(i_wdata[1]))
		else $error("start command not taken");
	stop_alone_a: assert property (i_wr && i_addr == ADR_CMD && i_wdata[2:0] == 3'h2
		&& s_ff.st == ST_WAIT |=> s_ff.st == ST_STOP ##1 !o_scl_oe_n)
		else $error("held bus not released by stop");
	cancel_cmd_a: assert property (i_wr && i_addr == ADR_CMD && i_wdata[CMD_CANCEL_BIT]
		&& s_ff.st inside {ST_ADDR, ST_TXD, ST_RXD} |=> s_ff.st == ST_STOP)
		else $error("cancel did not abort");
	tx_push_a: assert property (i_wr && i_addr == ADR_DATA && s_ff.txc != FIFO_FULL
		&& !tx_pop |=> s_ff.txc == $past(s_ff.txc) + (FIFO_AW+1)'(1))
		else $error("data write not pushed");
	rx_pop_a: assert property (i_rd && i_addr == ADR_DATA && s_ff.rxc != '0 && !rx_push
		|=> s_ff.rxc == $past(s_ff.rxc) - (FIFO_AW+1)'(1) && o_rdata[31:8] == '0)
		else $error("data read not popped");
	tx_stall_a: assert property (tick && s_ff.st == ST_TXD && s_ff.bitn == BIT_PREP
		&& s_ff.txc == '0 && s_ff.sent == '0 && s_ff.words != '0 && !(i_wr && i_addr == ADR_CMD)
		|=> s_ff.st == ST_TXD && s_ff.stalled)
		else $error("first byte did not stall");
	wait_state_a: assert property ($rose(s_ff.st == ST_WAIT) |-> !s_ff.stop_req
		&& status[ST_WAITING_BIT] && !o_scl_oe_n)
		else $error("wait entered with stop requested");
	addr_seven_a: assert property ($rose(s_ff.st == ST_ADDR) && !s_ff.a10
		|-> s_ff.sh == {s_ff.taddr[6:0], s_ff.dir})
		else $error("seven bit address byte wrong");
	tally_cap_a: assert property (s_ff.sent <= TALLY_MAX)
		else $error("sent tally beyond cap");
	tx_nack_a: assert property (tick && !stretch && last_ph && s_ff.st == ST_TXD
		&& s_ff.bitn == BIT_ACK && s_ff.smp && !i_wr |=> s_ff.nack_d && s_ff.st != ST_TXD)
		else $error("data nack did not end transfer");
endmodule // i2cm_ctrl

// ==== i2cm_slave_model.sv ====
// behavioural i2c slave: acks its address, records bytes, serves read data
`timescale 1ns/10ps
module i2cm_slave_model #(
	parameter logic [6:0] SLV_ADDR = 7'h2A
) (
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic [3:0] i_nack_at,
	output logic o_sda_oe_n
);
	logic [7:0] sh = 8'h00;
	logic [7:0] rdat;
	logic [7:0] rxq[$];
	logic mackq[$];
	int cnt = 0;
	int nb = 0;
	logic rdir = 1'b0;
	logic frame = 1'b0;
	initial o_sda_oe_n = 1'b1;
	// confirm a moment later: a same-step scl fall is no start or stop
	always @(negedge i_sda)
	begin
		#1;
		if (i_scl)
		begin
			frame = 1'b1;
			cnt = 0;
			nb = 0;
			rdir = 1'b0;
		end
	end
	always @(posedge i_sda)
	begin
		#1;
		if (i_scl)
			frame = 1'b0;
	end
	always @(posedge i_scl)
		if (frame)
		begin
			if (cnt < 8)
				sh = {sh[6:0], i_sda};
			else if (rdir && nb > 0)
				mackq.push_back(!i_sda);
			cnt = cnt + 1;
		end
	always @(negedge i_scl)
		if (frame)
		begin
			o_sda_oe_n = 1'b1;
			if (cnt == 8 && !(rdir && nb > 0))
			begin
				if (nb == 0)
					rdir = sh[0];
				rxq.push_back(sh);
				// address or ten-bit header acked; the chosen data byte nacked
				if (nb == 0)
					o_sda_oe_n = !(sh[7:1] == SLV_ADDR || sh[7:3] == 5'h1E);
				else
					o_sda_oe_n = (nb == 32'(i_nack_at));
			end
			if (cnt == 9)
			begin
				cnt = 0;
				nb = nb + 1;
			end
			rdat = 8'hA0 + nb[7:0] - 8'h01;
			// stop serving once the master nacked, so its stop can pass
			if (rdir && nb > 0 && cnt < 8 && (mackq.size() == 0 || mackq[$]))
				o_sda_oe_n = rdat[7 - cnt];
		end
endmodule // i2cm_slave_model

// ==== i2c_master_transfer_control_tb_top.sv ====
// self-checking bench: register port stimulus against a slave model
`timescale 1ns/10ps
module i2c_master_transfer_control_tb_top;
	import i2cm_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic scl_oe_n;
	logic sda_oe_n;
	logic scl_o;
	logic sda_o;
	logic slv_oe_n;
	logic [3:0] nack_at = 4'hF;
	logic [7:0] seed = 8'h61;
	logic [31:0] v;
	logic [31:0] w;
	logic [7:0] b[$];
	logic [7:0] e[$];
	longint t_rise[$];
	logic [4:0] ra[3] = '{ADR_DIV, ADR_WORDS, ADR_TADDR};
	logic [31:0] rm[3] = '{32'h800000FF, 32'h000007FF, 32'h000087FF};
	int err_total = 0;
	int checked = 0;
	// open-drain wires with pull-ups
	wire scl_w = scl_oe_n | scl_o;
	wire sda_w = (sda_oe_n | sda_o) & slv_oe_n;
	always #50 clk = ~clk;
	always @(posedge scl_w) t_rise.push_back($time);
	i2cm_ctrl u_dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_scl(scl_w), .o_scl(scl_o),
		.o_scl_oe_n(scl_oe_n), .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe_n(sda_oe_n));
	i2cm_slave_model u_slv (.i_scl(scl_w), .i_sda(sda_w), .i_nack_at(nack_at),
		.o_sda_oe_n(slv_oe_n));
	// ----
	// helpers
	// ----
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [31:0] bit_ns(input logic [7:0] d, input logic f);
		return ({24'h0, d} + 32'h1) * (f ? 32'h19 : 32'h14) * 32'h64;
	endfunction
	function automatic logic [7:0] hdr10(input logic [9:0] a);
		return {5'h1E, a[9:8], 1'b0};
	endfunction
	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// poll a register field; a bound keeps a hung transfer from stalling the run
	task automatic wait_rg(input logic [4:0] a, input logic [31:0] m, input logic [31:0] x);
		int n;
		n = 0;
		rreg(a, v);
		while ((v & m) !== x)
		begin
			n++;
			if (n > 5000)
			begin
				err_total++;
				results();
			end
			rreg(a, v);
		end
	endtask
	task automatic push_rnd();
		seed = lfsr(seed);
		b.push_back(seed);
		wreg(ADR_DATA, {24'h0, seed});
	endtask
	task automatic start_tx(input logic [31:0] ta, input logic [10:0] n_w, input int n,
		input logic [2:0] cmd);
		b.delete();
		u_slv.rxq.delete();
		u_slv.mackq.delete();
		t_rise.delete();
		wreg(ADR_WORDS, {21'h0, n_w});
		wreg(ADR_TADDR, ta);
		repeat (n) push_rnd();
		wreg(ADR_CMD, {29'h0, cmd});
	endtask
	task automatic cmpq(input logic [7:0] a0);
		e = {a0, b};
		chk(32'(u_slv.rxq.size()), 32'(e.size()));
		foreach (e[i])
			chk({24'h0, u_slv.rxq[i]}, {24'h0, e[i]});
	endtask
	// ----
	// scenarios
	// ----
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rreg(ADR_DIV, v);
		chk(v, 32'h18);
		rreg(ADR_WORDS, v);
		chk(v, 32'h1);
		rreg(ADR_TADDR, v);
		chk(v, 32'h0);
		rreg(ADR_CMD, v);
		chk(v, 32'h0);
		rreg(5'h02, v);
		chk(v, 32'h0);
		for (int i = 0; i < 12; i++)
		begin
			seed = lfsr(seed);
			w = {seed, ~seed, seed, ~seed};
			wreg(ra[i % 3], w);
			rreg(ra[i % 3], v);
			chk(v, w & rm[i % 3]);
		end
		wreg(ADR_DIV, 32'h4);
		start_tx(32'h54, 11'h3, 3, 3'h3);
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		cmpq(8'h54);
		rreg(ADR_TALLY, v);
		chk(v, 32'h3);
		chk(32'(t_rise[1] - t_rise[0]), bit_ns(8'h4, 1'b0));
		wreg(ADR_DIV, 32'h80000000);
		nack_at <= 4'h3;
		start_tx(32'h54, 11'h4, 3, 3'h3);
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		nack_at <= 4'hF;
		cmpq(8'h54);
		rreg(ADR_TALLY, v);
		chk(v, 32'h3);
		rreg(ADR_STATUS, v);
		chk(32'(v[ST_NACKDATA_BIT]), 32'h1);
		chk(32'(t_rise[1] - t_rise[0]), bit_ns(8'h0, 1'b1));
		start_tx(32'h55, 11'h3, 0, 3'h3);
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		cmpq(8'h55);
		for (int i = 0; i < 4; i++)
		begin
			rreg(ADR_DATA, v);
			chk(v, i < 3 ? 32'hA0 + 32'(i) : 32'h0);
		end
		chk(32'(u_slv.mackq.size()), 32'h3);
		chk({29'h0, u_slv.mackq[0], u_slv.mackq[1], u_slv.mackq[2]}, 32'h6);
		start_tx(32'h54, 11'h1, 1, 3'h1);
		wait_rg(ADR_STATUS, 32'h4, 32'h4);
		chk({30'h0, scl_w, u_slv.frame}, 32'h1);
		wreg(ADR_CMD, 32'h2);
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		chk({29'h0, scl_w, sda_w, u_slv.frame}, 32'h6);
		cmpq(8'h54);
		start_tx({16'h0, 1'b1, 4'h0, 10'h2B5, 1'b0}, 11'h1, 1, 3'h3);
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		b.push_front(8'hB5);
		cmpq(hdr10(10'h2B5));
		start_tx({16'h0, 1'b1, 4'h0, 10'h2B5, 1'b1}, 11'h1, 0, 3'h3);
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		b = {8'hB5, hdr10(10'h2B5) | 8'h01};
		cmpq(hdr10(10'h2B5));
		rreg(ADR_DATA, v);
		chk(v, 32'hA0);
		start_tx(32'h54, 11'h7FF, 4, 3'h3);
		wait_rg(ADR_TALLY, 32'h2, 32'h2);
		wreg(ADR_WORDS, 32'h1);
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		rreg(ADR_TALLY, v);
		chk(32'(v == 32'h2 || v == 32'h3), 32'h1);
		// leftover bytes of the continuous run go out ahead of the new one
		wreg(ADR_CTRL, 32'h1);
		start_tx(32'h54, 11'h5, 1, 3'h3);
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		rreg(ADR_TALLY, v);
		chk(v, 32'(u_slv.rxq.size() - 1));
		chk({24'h0, u_slv.rxq[$]}, {24'h0, b[0]});
		rreg(ADR_STATUS, v);
		chk(32'(v[ST_TXEMPTY_BIT]), 32'h1);
		start_tx(32'h54, 11'h1, 0, 3'h3);
		wait_rg(ADR_STATUS, 32'h8, 32'h8);
		push_rnd();
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		cmpq(8'h54);
		start_tx(32'h55, 11'h8, 0, 3'h3);
		wait_rg(ADR_STATUS, 32'h100, 32'h100);
		wreg(ADR_CMD, 32'h4);
		wait_rg(ADR_STATUS, 32'h6, 32'h2);
		chk(32'(u_slv.mackq.size() < 8), 32'h1);
		repeat (8) rreg(ADR_DATA, v);
		rreg(ADR_STATUS, v);
		chk(32'(v[ST_RXNEMPTY_BIT]), 32'h0);
		results();
	end
endmodule // i2c_master_transfer_control_tb_top
